// ### core/rxpef_top.v
// Receive packet filter, shared buffer, reader path and register slave
`timescale 1ns/10ps
`include "rxpef_map.vh"
module rxpef_top #(
  parameter N_PORTS = 4,
  parameter PW      = 2,
  parameter DW      = 64,
  parameter MW      = 3,
  parameter AW      = 4
) (
  input  wire               clk_sys,
  input  wire               resetn,
  input  wire               clk_en,
  // Write stream from the protocol path
  input  wire               wr_valid,
  input  wire [PW-1:0]      wr_port,
  input  wire [DW-1:0]      wr_data,
  input  wire               wr_sop,
  input  wire               wr_eop,
  input  wire               wr_err,
  input  wire [MW-1:0]      empty_byte_count,
  // Reader side
  output wire               rd_valid,
  input  wire               rd_ready,
  output wire [PW-1:0]      rd_port,
  output wire [DW-1:0]      rd_data,
  output wire               rd_pkt_start,
  output wire               rd_pkt_end,
  output wire               rd_pkt_error,
  output wire [MW-1:0]      rd_empty_count,
  // Write-side markers of each buffered entry
  output reg                tx_side_pkt_end_ff,
  output reg                tx_side_pkt_error_ff,
  // Status
  output reg  [N_PORTS-1:0] missing_start_err_ff,
  output reg  [N_PORTS-1:0] missing_end_err_ff,
  output reg  [N_PORTS-1:0] fifo_overflow_err_ff,
  output reg  [PW-1:0]      failing_port_addr_ff,
  // Register slave
  input  wire [3:0]         av_address,
  input  wire               av_read,
  input  wire               av_write,
  input  wire [31:0]        av_writedata,
  input  wire [3:0]         av_byteenable,
  output reg  [31:0]        av_readdata,
  output wire               av_waitrequest
);

  localparam EW    = PW + 3 + MW + DW;
  localparam DEPTH = 1 << AW;
  localparam CW    = AW + 1;
  localparam [CW-1:0] FULL_CNT = {1'b1, {AW{1'b0}}};
  localparam [CW-1:0] NORM_MAX = {1'b0, {AW{1'b1}}};

  // Entry layout: {port, sop, eop, err, mty, data}
  localparam E_MTY = DW;
  localparam E_ERR = DW + MW;
  localparam E_EOP = DW + MW + 1;
  localparam E_SOP = DW + MW + 2;
  localparam E_PRT = DW + MW + 3;

  function [N_PORTS-1:0] port_mask;
    input [PW-1:0] p;
    begin
      port_mask = {{(N_PORTS-1){1'b0}}, 1'b1} << p;
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [N_PORTS-1:0] open_ff;
  reg [N_PORTS-1:0] disc_ff;
  reg [N_PORTS-1:0] wsop_ff;
  reg [CW-1:0]      count_ff;
  reg [CW-1:0]      eop_cnt_ff;
  reg [AW-1:0]      wp_ff;
  reg [AW-1:0]      rp_ff;
  reg               inflight_ff;
  reg               chk_en_ff;
  reg               eam_ff;
  reg               ack_ff;

  reg [N_PORTS-1:0] nxt_open_ff;
  reg [N_PORTS-1:0] nxt_disc_ff;
  reg [N_PORTS-1:0] nxt_wsop_ff;
  reg [N_PORTS-1:0] nxt_ovf_ff;
  reg [N_PORTS-1:0] nxt_msop_ff;
  reg [N_PORTS-1:0] nxt_meop_ff;
  reg [PW-1:0]      nxt_fail_ff;
  reg               want_wr;
  reg               want_force;
  reg               wr_en;
  reg               e_eop;
  reg               e_err;
  reg               e_blank;
  reg               p_open;

  wire [N_PORTS-1:0] pm;
  wire               mty_bad;
  wire               room_norm;
  wire               room_force;
  wire [EW-1:0]      wr_entry;
  wire [EW-1:0]      mem_q;
  wire               fetch;
  wire [1:0]         skid_lvl;
  wire [2:0]         pending;
  wire [EW-1:0]      rd_entry;
  wire               bus_req;
  wire               bus_take;

  assign pm         = port_mask(wr_port);
  // A word with leftover bytes must also close the packet
  assign mty_bad    = (empty_byte_count != {MW{1'b0}}) & ~wr_eop;
  // Last slot kept back so a truncating end marker still fits
  assign room_norm  = (count_ff < NORM_MAX);
  assign room_force = (count_ff < FULL_CNT);

  // --------------------------------------------------------------------------
  // Write-side filter
  // --------------------------------------------------------------------------
  always @* begin
    nxt_open_ff = open_ff;
    nxt_disc_ff = disc_ff;
    nxt_wsop_ff = wsop_ff;
    nxt_ovf_ff  = fifo_overflow_err_ff;
    nxt_msop_ff = {N_PORTS{1'b0}};
    nxt_meop_ff = {N_PORTS{1'b0}};
    nxt_fail_ff = failing_port_addr_ff;
    want_wr     = 1'b0;
    want_force  = 1'b0;
    wr_en       = 1'b0;
    e_eop       = wr_eop;
    e_err       = wr_err;
    e_blank     = 1'b0;
    p_open      = open_ff[wr_port];
    if (wr_valid) begin
      if (!chk_en_ff) begin
        want_wr = 1'b1;
      // RULE_16: hold off until empty, then until start
      end else if (fifo_overflow_err_ff[wr_port] |
                   (wsop_ff[wr_port] & ~wr_sop)) begin
        want_wr = 1'b0;
      // RULE_03: discard until end marker
      // RULE_09: discard until end marker
      end else if (disc_ff[wr_port]) begin
        // RULE_10: no flag while rejecting
        if (wr_eop)
          nxt_disc_ff[wr_port] = 1'b0;
      end else if (!p_open) begin
        nxt_wsop_ff[wr_port] = 1'b0;
        if (!wr_sop) begin
          // RULE_02: orphan word flags start
          nxt_msop_ff          = pm;
          // RULE_04: orphan word never written
          nxt_disc_ff[wr_port] = ~wr_eop;
        end else if (mty_bad) begin
          // RULE_13: close at once with error
          want_force           = 1'b1;
          e_eop                = 1'b1;
          e_err                = 1'b1;
          nxt_meop_ff          = pm;
          nxt_fail_ff          = wr_port;
          // RULE_12: drop rest until end
          nxt_disc_ff[wr_port] = 1'b1;
        end else begin
          // RULE_18: track packet per port
          want_wr              = 1'b1;
          nxt_open_ff[wr_port] = ~wr_eop;
        end
      end else if (wr_sop) begin
        // RULE_05: start inside open packet
        nxt_meop_ff          = pm;
        // RULE_08: latch failing port
        nxt_fail_ff          = wr_port;
        // RULE_06: blank error end entry
        want_force           = 1'b1;
        e_blank              = 1'b1;
        nxt_open_ff[wr_port] = 1'b0;
        nxt_disc_ff[wr_port] = ~wr_eop;
      end else if (mty_bad) begin
        // RULE_13: word becomes error end
        want_force           = 1'b1;
        e_eop                = 1'b1;
        e_err                = 1'b1;
        nxt_meop_ff          = pm;
        nxt_fail_ff          = wr_port;
        nxt_open_ff[wr_port] = 1'b0;
        // RULE_12: drop rest until end
        nxt_disc_ff[wr_port] = 1'b1;
      end else begin
        want_wr              = 1'b1;
        nxt_open_ff[wr_port] = ~wr_eop;
      end
    end
    if (want_wr & room_norm) begin
      wr_en = 1'b1;
    end else if (want_force & room_force) begin
      wr_en = 1'b1;
    end else if (want_wr | want_force) begin
      // RULE_16: overflow truncates the open packet
      nxt_ovf_ff  = fifo_overflow_err_ff | pm;
      nxt_wsop_ff = wsop_ff | pm;
      nxt_open_ff[wr_port] = 1'b0;
      nxt_disc_ff[wr_port] = 1'b0;
      // Truncation lost only if the reserve slot is taken too
      if (chk_en_ff & p_open & ~want_force & room_force) begin
        wr_en   = 1'b1;
        e_blank = 1'b1;
      end
    end
    // RULE_16: release once the buffer has drained
    if ((count_ff == {CW{1'b0}}) & ~wr_en & ~(want_wr | want_force))
      nxt_ovf_ff = {N_PORTS{1'b0}};
  end

  // RULE_06: blank entries close the packet with error
  assign wr_entry = e_blank ?
    {wr_port, 1'b0, 1'b1, 1'b1, {MW{1'b0}}, {DW{1'b0}}} :
    {wr_port, wr_sop, e_eop, e_err, empty_byte_count, wr_data};

  // --------------------------------------------------------------------------
  // Filter and buffer registers
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!resetn) begin
      open_ff              <= {N_PORTS{1'b0}};
      disc_ff              <= {N_PORTS{1'b0}};
      wsop_ff              <= {N_PORTS{1'b0}};
      fifo_overflow_err_ff <= {N_PORTS{1'b0}};
      missing_start_err_ff <= {N_PORTS{1'b0}};
      missing_end_err_ff   <= {N_PORTS{1'b0}};
      failing_port_addr_ff <= {PW{1'b0}};
      tx_side_pkt_end_ff   <= 1'b0;
      tx_side_pkt_error_ff <= 1'b0;
      count_ff             <= {CW{1'b0}};
      eop_cnt_ff           <= {CW{1'b0}};
      wp_ff                <= {AW{1'b0}};
      rp_ff                <= {AW{1'b0}};
      inflight_ff          <= 1'b0;
    end else if (clk_en) begin
      // RULE_18: per-port state updated per word
      open_ff              <= nxt_open_ff;
      disc_ff              <= nxt_disc_ff;
      wsop_ff              <= nxt_wsop_ff;
      fifo_overflow_err_ff <= nxt_ovf_ff;
      // RULE_15: single-cycle error pulses
      missing_start_err_ff <= nxt_msop_ff;
      missing_end_err_ff   <= nxt_meop_ff;
      failing_port_addr_ff <= nxt_fail_ff;
      // RULE_14: write-side error on forced end
      tx_side_pkt_end_ff   <= wr_en & wr_entry[E_EOP];
      tx_side_pkt_error_ff <= wr_en & wr_entry[E_ERR];
      if (wr_en)
        wp_ff <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
      if (fetch)
        rp_ff <= rp_ff + {{(AW-1){1'b0}}, 1'b1};
      count_ff <= count_ff + {{(CW-1){1'b0}}, wr_en}
                           - {{(CW-1){1'b0}}, fetch};
      eop_cnt_ff <= eop_cnt_ff
                  + {{(CW-1){1'b0}}, wr_en & wr_entry[E_EOP]}
                  - {{(CW-1){1'b0}}, inflight_ff & mem_q[E_EOP]};
      inflight_ff <= fetch;
    end
  end

  rxpef_mem #(
    .EW (EW),
    .AW (AW)
  ) u_mem (
    .clk_sys  (clk_sys),
    .clk_en   (clk_en),
    .we       (wr_en),
    .waddr    (wp_ff),
    .wdata    (wr_entry),
    .re       (fetch),
    .raddr    (rp_ff),
    .rdata_ff (mem_q)
  );

  // --------------------------------------------------------------------------
  // Reader path
  // --------------------------------------------------------------------------
  // Fetch only what the two-entry buffer can still hold
  assign pending = {1'b0, skid_lvl} + {2'b00, inflight_ff};
  // End-available mode waits for a whole packet, one read in flight
  assign fetch = (count_ff != {CW{1'b0}}) & (pending < 3'd2) &
                 (~eam_ff | ((eop_cnt_ff != {CW{1'b0}}) & ~inflight_ff)) &
                 clk_en;

  rxpef_skid #(
    .W (EW)
  ) u_skid (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .in_valid  (inflight_ff),
    .in_ready  (),
    .in_data   (mem_q),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_entry),
    .level     (skid_lvl)
  );

  // RULE_07: forced entry shows error and end together
  assign rd_pkt_end     = rd_entry[E_EOP];
  assign rd_pkt_error   = rd_entry[E_ERR];
  assign rd_pkt_start   = rd_entry[E_SOP];
  assign rd_port        = rd_entry[E_PRT +: PW];
  assign rd_empty_count = rd_entry[E_MTY +: MW];
  assign rd_data        = rd_entry[DW-1:0];

  // --------------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------------
  // One wait state on every access keeps read data registered
  assign bus_req        = av_read | av_write;
  assign av_waitrequest = bus_req & ~(ack_ff & clk_en);
  assign bus_take       = bus_req & ack_ff & clk_en;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      ack_ff      <= 1'b0;
      chk_en_ff   <= `RXPEF_CTRL_CHK_RST;
      eam_ff      <= `RXPEF_CTRL_EAM_RST;
      av_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_ff <= bus_req & ~ack_ff;
      if (av_read & ~ack_ff) begin
        case (av_address)
          `RXPEF_CTRL_OFS: begin
            av_readdata <= 32'h0000_0000;
            av_readdata[`RXPEF_CTRL_CHK_BIT] <= chk_en_ff;
            av_readdata[`RXPEF_CTRL_EAM_BIT] <= eam_ff;
          end
          `RXPEF_STAT_OFS: begin
            av_readdata <= 32'h0000_0000;
            av_readdata[`RXPEF_STAT_FAIL_LSB +: PW] <= failing_port_addr_ff;
            av_readdata[`RXPEF_STAT_EMPTY_BIT] <=
              (count_ff == {CW{1'b0}});
          end
          `RXPEF_OVF_OFS: begin
            av_readdata <= {{(32-N_PORTS){1'b0}}, fifo_overflow_err_ff};
          end
          `RXPEF_LEVEL_OFS: begin
            av_readdata <= {{(32-CW){1'b0}}, count_ff};
          end
          default: begin
            av_readdata <= 32'h0000_0000;
          end
        endcase
      end
      // RULE_01: software enables the filter
      if (bus_take & av_write & (av_address == `RXPEF_CTRL_OFS) &
          av_byteenable[0]) begin
        chk_en_ff <= av_writedata[`RXPEF_CTRL_CHK_BIT];
        eam_ff    <= av_writedata[`RXPEF_CTRL_EAM_BIT];
      end
    end
  end

endmodule

// ### pkg/rxpef_map.vh
// Register map, field positions and reset values of the receive packet filter
//
// Operation
// RULE_01: Filter validity on FIFO write side when enabled
// RULE_02: Orphan end or payload raises missing-start
// RULE_03: After missing-start, drop port data until end
// RULE_04: Data without start never enters the buffer
// RULE_05: Start on open packet pulses missing-end
// RULE_06: Missing-end closes packet with error end entry
// RULE_07: Forced end reads out with error and end
// RULE_08: Missing-end errors latch failing port address
// RULE_09: After missing-end, discard port data until end
// RULE_10: No extra missing-end pulses while discarding
// RULE_11: Writer keeps empty count zero without end
// RULE_12: Nonzero empty count without end starts discard
// RULE_13: Nonzero empty count forces error end, pulses
// RULE_14: Forced end raises write-side packet error
// RULE_15: Error flags are one-cycle pulses per detection
// RULE_16: Overflow holds until empty, then await start
// RULE_17: Use end-available read mode with checking
// RULE_18: Per-port open and discard bits, reset cleared
`ifndef RXPEF_MAP_VH
`define RXPEF_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RXPEF_CTRL_OFS       4'h0
`define RXPEF_STAT_OFS       4'h4
`define RXPEF_OVF_OFS        4'h8
`define RXPEF_LEVEL_OFS      4'hc

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RXPEF_CTRL_CHK_BIT   0
`define RXPEF_CTRL_EAM_BIT   1
`define RXPEF_STAT_FAIL_LSB  0
`define RXPEF_STAT_EMPTY_BIT 16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RXPEF_CTRL_CHK_RST   1'b1
`define RXPEF_CTRL_EAM_RST   1'b0

`endif

// ### core/rxpef_mem.v
// Buffer storage with registered read port
`timescale 1ns/10ps
module rxpef_mem #(
  parameter EW = 72,
  parameter AW = 4
) (
  input  wire          clk_sys,
  input  wire          clk_en,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [EW-1:0] wdata,
  input  wire          re,
  input  wire [AW-1:0] raddr,
  output reg  [EW-1:0] rdata_ff
);

  reg [EW-1:0] store [0:(1<<AW)-1];

  // No reset on the array; read data qualified by the caller
  always @(posedge clk_sys) begin
    if (clk_en) begin
      if (we)
        store[waddr] <= wdata;
      if (re)
        rdata_ff <= store[raddr];
    end
  end

endmodule

// ### core/rxpef_skid.v
// Two-entry valid/ready buffer
`timescale 1ns/10ps
module rxpef_skid #(
  parameter W = 72
) (
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire         clk_en,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data,
  output wire [1:0]   level
);

  reg [W-1:0] d0_ff;
  reg [W-1:0] d1_ff;
  reg [1:0]   cnt_ff;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_ff != 2'd2) & clk_en;
  assign out_valid = (cnt_ff != 2'd0);
  assign out_data  = d0_ff;
  assign level     = cnt_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready & clk_en;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      d0_ff  <= {W{1'b0}};
      d1_ff  <= {W{1'b0}};
      cnt_ff <= 2'd0;
    end else if (clk_en) begin
      if (push & pop) begin
        if (cnt_ff == 2'd1) begin
          d0_ff <= in_data;
        end else begin
          d0_ff <= d1_ff;
          d1_ff <= in_data;
        end
      end else if (push) begin
        if (cnt_ff == 2'd0)
          d0_ff <= in_data;
        else
          d1_ff <= in_data;
        cnt_ff <= cnt_ff + 2'd1;
      end else if (pop) begin
        d0_ff  <= d1_ff;
        cnt_ff <= cnt_ff - 2'd1;
      end
    end
  end

endmodule

// ### verif/rxpef_asserts.sv
// Concurrent checks on the packet filter ports
`timescale 1ns/10ps
module rxpef_asserts #(
  parameter N_PORTS = 4,
  parameter PW      = 2,
  parameter DW      = 64,
  parameter MW      = 3,
  parameter AW      = 4
) (
  input wire               clk_sys,
  input wire               resetn,
  input wire               wr_valid,
  input wire [PW-1:0]      wr_port,
  input wire               wr_sop,
  input wire               wr_eop,
  input wire [MW-1:0]      empty_byte_count,
  input wire               rd_valid,
  input wire               rd_ready,
  input wire [PW-1:0]      rd_port,
  input wire [DW-1:0]      rd_data,
  input wire               rd_pkt_end,
  input wire               rd_pkt_error,
  input wire               tx_side_pkt_end_ff,
  input wire               tx_side_pkt_error_ff,
  input wire [N_PORTS-1:0] missing_start_err_ff,
  input wire [N_PORTS-1:0] missing_end_err_ff,
  input wire [N_PORTS-1:0] fifo_overflow_err_ff,
  input wire [PW-1:0]      failing_port_addr_ff,
  input wire               av_read,
  input wire               av_write,
  input wire               av_waitrequest
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ----------
  // Properties
  // ----------
  wait_one_a: assert property ($rose(av_read) |->
    av_waitrequest ##1 !av_waitrequest) else $error("bus wait not one");
  msop_cause_a: assert property (|missing_start_err_ff |->
    $past(wr_valid) && missing_start_err_ff[$past(wr_port)])
    else $error("missing start flag without its word");
  meop_cause_a: assert property (|missing_end_err_ff |->
    $past(wr_valid) && missing_end_err_ff[$past(wr_port)])
    else $error("missing end flag without its word");
  meop_why_a: assert property (|missing_end_err_ff |->
    $past(wr_sop) || ($past(empty_byte_count) != 0 && !$past(wr_eop)))
    else $error("missing end flag without a cause");
  fail_addr_a: assert property (|missing_end_err_ff |->
    failing_port_addr_ff == $past(wr_port))
    else $error("failing port address wrong");
  err_with_end_a: assert property (|missing_end_err_ff &&
    !(|(missing_end_err_ff & fifo_overflow_err_ff)) |->
    tx_side_pkt_end_ff && tx_side_pkt_error_ff)
    else $error("forced end without write side error and end");
  rd_err_end_a: assert property (rd_valid && rd_pkt_error |->
    rd_pkt_end) else $error("read error without end");
  rd_hold_a: assert property (rd_valid && !rd_ready |=>
    rd_valid && $stable(rd_data) && $stable(rd_port))
    else $error("read word changed while stalled");
  ovf_cause_a: assert property ($rose(|fifo_overflow_err_ff) |->
    $past(wr_valid)) else $error("overflow without a write");
  cover property (|missing_end_err_ff);
  cover property (|fifo_overflow_err_ff);
  cover property (rd_valid && rd_pkt_error);
endmodule

bind rxpef_top rxpef_asserts #(.N_PORTS(N_PORTS), .PW(PW), .DW(DW),
  .MW(MW), .AW(AW)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .wr_valid(wr_valid),
  .wr_port(wr_port), .wr_sop(wr_sop), .wr_eop(wr_eop),
  .empty_byte_count(empty_byte_count), .rd_valid(rd_valid),
  .rd_ready(rd_ready), .rd_port(rd_port), .rd_data(rd_data),
  .rd_pkt_end(rd_pkt_end), .rd_pkt_error(rd_pkt_error),
  .tx_side_pkt_end_ff(tx_side_pkt_end_ff),
  .tx_side_pkt_error_ff(tx_side_pkt_error_ff),
  .missing_start_err_ff(missing_start_err_ff),
  .missing_end_err_ff(missing_end_err_ff),
  .fifo_overflow_err_ff(fifo_overflow_err_ff),
  .failing_port_addr_ff(failing_port_addr_ff), .av_read(av_read),
  .av_write(av_write), .av_waitrequest(av_waitrequest));

// ### verif/rxpef_sink.sv
// Reader model that stalls and logs every word it takes
`timescale 1ns/10ps
module rxpef_sink (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        hold,
  input  wire        rd_valid,
  output logic       rd_ready,
  input  wire [1:0]  rd_port,
  input  wire [63:0] rd_data,
  input  wire        rd_pkt_start,
  input  wire        rd_pkt_end,
  input  wire        rd_pkt_error
);
  logic [68:0] got[$];
  logic        tick_ff;
  // drains while hold is low so an overflowed buffer empties
  always @(posedge clk_sys) begin
    if (!resetn) begin
      rd_ready <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      // Every other cycle stalled: output buffer must hold
      tick_ff <= !tick_ff;
      rd_ready <= !hold && tick_ff;
      if (rd_valid && rd_ready)
        got.push_back({rd_port, rd_pkt_start, rd_pkt_end, rd_pkt_error,
                       rd_data});
    end
  end
endmodule

// ### verif/rx_fifo_packet_error_filter_tb.sv
// Self-checking bench of the receive packet filter
`timescale 1ns/10ps
module rx_fifo_packet_error_filter_tb;
  logic clk_sys, resetn, clk_en, wr_valid, wr_sop, wr_eop, wr_err, hold;
  logic [1:0] wr_port, rd_port, fail_p;
  logic [63:0] wr_data, rd_data;
  logic [2:0] empty_byte_count;
  logic rd_valid, rd_ready, rd_pkt_start, rd_pkt_end, rd_pkt_error;
  logic tx_end, tx_err, av_read, av_write, av_waitrequest;
  logic [3:0] ms_ff, me_ff, ovf_ff, av_address, av_byteenable;
  logic [31:0] av_writedata, av_readdata, d;
  logic [68:0] exp[$];
  int mismatches, num_checks, ms_cnt[4], me_cnt[4], txe, m0, e0;
  int txn, n0;

  rxpef_top dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .wr_valid(wr_valid), .wr_port(wr_port), .wr_data(wr_data),
    .wr_sop(wr_sop), .wr_eop(wr_eop), .wr_err(wr_err),
    .empty_byte_count(empty_byte_count), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_port(rd_port), .rd_data(rd_data),
    .rd_pkt_start(rd_pkt_start), .rd_pkt_end(rd_pkt_end),
    .rd_pkt_error(rd_pkt_error), .rd_empty_count(),
    .tx_side_pkt_end_ff(tx_end), .tx_side_pkt_error_ff(tx_err),
    .missing_start_err_ff(ms_ff), .missing_end_err_ff(me_ff),
    .fifo_overflow_err_ff(ovf_ff), .failing_port_addr_ff(fail_p),
    .av_address(av_address), .av_read(av_read), .av_write(av_write),
    .av_writedata(av_writedata), .av_byteenable(av_byteenable),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest));
  rxpef_sink u_sink (.clk_sys(clk_sys), .resetn(resetn), .hold(hold),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_port(rd_port),
    .rd_data(rd_data), .rd_pkt_start(rd_pkt_start),
    .rd_pkt_end(rd_pkt_end), .rd_pkt_error(rd_pkt_error));

  always #10 clk_sys = ~clk_sys;
  // Pulse counters, read only while the stream is idle
  always @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (ms_ff[i] === 1'b1) ms_cnt[i]++;
      if (me_ff[i] === 1'b1) me_cnt[i]++;
    end
    if (tx_err === 1'b1) txe++;
    if (tx_end === 1'b1) txn++;
  end
  // -----
  // Tasks
  // -----
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input [68:0] g, input [68:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function logic [68:0] ent(input [1:0] p, input s, input e, input r,
                            input [7:0] v);
    return {p, s, e, r, 56'h0, v};
  endfunction
  // empty count zero unless eop
  // Only the empty-nonzero test breaks it on purpose
  task wr(input [1:0] p, input s, input e, input [2:0] m, input [7:0] v);
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    wr_port <= p;
    wr_sop <= s;
    wr_eop <= e;
    empty_byte_count <= m;
    wr_data <= {56'h0, v};
  endtask
  task idle(input int n);
    @(posedge clk_sys);
    wr_valid <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task avx(input w, input [3:0] a, input [31:0] wd, output [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    av_address <= a;
    av_write <= w;
    av_read <= !w;
    av_writedata <= wd;
    // Read at the edge itself, before the slave updates its flops
    do begin
      @(posedge clk_sys);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 50);
    if (av_waitrequest !== 1'b0) begin
      mismatches++;
      complete_run();
    end
    rd = av_readdata;
    av_read <= 1'b0;
    av_write <= 1'b0;
  endtask
  task rchk(input [3:0] a, input [31:0] e);
    avx(1'b0, a, 32'h0, d);
    chk(69'(d), 69'(e));
  endtask
  task endt(input string nm);
    idle(60);
    chk(69'(u_sink.got.size()), 69'(exp.size()));
    foreach (exp[i]) if (i < u_sink.got.size()) chk(u_sink.got[i], exp[i]);
    exp.delete();
    u_sink.got.delete();
    $display("test %s done, mismatches %0d", nm, mismatches);
  endtask
  // ---------
  // Sequences
  // ---------
  initial begin
    clk_sys = 0; resetn = 0; clk_en = 1; wr_valid = 0; wr_port = 0;
    wr_data = 0; wr_sop = 0; wr_eop = 0; wr_err = 0; hold = 0;
    empty_byte_count = 0; av_address = 0; av_read = 0; av_write = 0;
    av_writedata = 0; av_byteenable = 4'hf;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rchk(4'h0, 32'h1);
    rchk(4'h2, 32'h0);
    rchk(4'h4, 32'h10000);
    endt("registers");
    wr(1, 1, 0, 0, 8'h11); wr(1, 0, 0, 0, 8'h12); wr(1, 0, 1, 3, 8'h13);
    exp = '{ent(1,1,0,0,8'h11), ent(1,0,0,0,8'h12), ent(1,0,1,0,8'h13)};
    endt("good packet");
    m0 = ms_cnt[2];
    wr(2, 0, 0, 0, 8'h21); wr(2, 0, 1, 0, 8'h22); wr(2, 1, 1, 0, 8'h23);
    exp = '{ent(2,1,1,0,8'h23)};
    endt("missing start");
    chk(69'(ms_cnt[2] > m0), 69'(1));
    e0 = me_cnt[3]; m0 = txe; n0 = txn;
    wr(3, 1, 0, 0, 8'h31); wr(3, 1, 0, 0, 8'h32); wr(3, 0, 0, 0, 8'h33);
    wr(3, 0, 1, 0, 8'h34); wr(3, 1, 1, 0, 8'h35);
    exp = '{ent(3,1,0,0,8'h31), ent(3,0,1,1,8'h0), ent(3,1,1,0,8'h35)};
    endt("missing end");
    chk(69'(me_cnt[3] - e0), 69'(1));
    chk(69'(txe - m0), 69'(1));
    chk(69'(txn - n0), 69'(2));
    rchk(4'h4, 32'h10003);
    e0 = me_cnt[0];
    wr(0, 1, 0, 0, 8'h41); wr(0, 0, 0, 2, 8'h42); wr(0, 0, 0, 0, 8'h43);
    wr(0, 0, 1, 0, 8'h44);
    exp = '{ent(0,1,0,0,8'h41), ent(0,0,1,1,8'h42)};
    endt("empty nonzero");
    chk(69'(me_cnt[0] - e0), 69'(1));
    chk(69'(fail_p), 69'(0));
    avx(1'b1, 4'h0, 32'h0, d);
    m0 = ms_cnt[2];
    wr(2, 0, 0, 0, 8'h51);
    exp = '{ent(2,0,0,0,8'h51)};
    endt("checks off");
    chk(69'(ms_cnt[2] - m0), 69'(0));
    avx(1'b1, 4'h0, 32'h3, d);
    rchk(4'h0, 32'h3);
    @(posedge clk_sys);
    hold <= 1'b1;
    wr(1, 1, 0, 0, 8'h60);
    for (int i = 1; i < 24; i++) wr(1, 0, 0, 0, 8'(i));
    idle(4);
    chk(69'(ovf_ff), 69'(4'h2));
    rchk(4'h8, 32'h2);
    hold <= 1'b0;
    idle(150);
    chk(69'(ovf_ff), 69'(4'h0));
    rchk(4'hc, 32'h0);
    chk(69'(u_sink.got.size()), 69'(16));
    chk(u_sink.got[14], ent(1,0,0,0,8'h0e));
    chk(u_sink.got[15], ent(1,0,1,1,8'h0));
    u_sink.got.delete();
    wr(1, 0, 1, 0, 8'h70); wr(1, 1, 1, 0, 8'h71);
    exp = '{ent(1,1,1,0,8'h71)};
    endt("overflow");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end
endmodule
